//--- swd_slave_ctrl.sv
/*
 * Slave state controller with a network output watchdog and a
 * local-processor watchdog, configured over an AXI4-Lite register slave.
 * Assumes master requests and exchange strobes synchronous to aclk.
 */
`timescale 1ns/1ns
`include "swd_consts.svh"

module swd_slave_ctrl #(
    parameter int ADDR_W = 8,
    parameter int OUT_W = 32,
    parameter int IN_W = 32,
    parameter int WD_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req_valid,
    input wire swd_pkg::swd_state_t req_state,
    input wire logic mbx_cfg_ok,
    input wire logic pd_cfg_ok,
    input wire logic dc_cfg_ok,
    input wire logic pd_xfer_ok,
    input wire logic [OUT_W-1:0] pd_out_data,
    input wire logic lp_access,
    input wire logic [IN_W-1:0] in_data,
    output swd_pkg::swd_state_t cur_state,
    output logic state_err,
    output logic mbx_allowed,
    output logic file_only,
    output logic pd_allowed,
    output logic capture_inputs,
    output logic [IN_W-1:0] dpm_in_data,
    output logic [OUT_W-1:0] phys_out,
    output logic nw_wd_expired,
    output logic lp_wd_expired
);
    // ***************************************************************
    // Declarations
    // ***************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    swd_pkg::swd_state_t state_ff, nxt_state;
    logic err_ff, nxt_err;
    logic cap_ff, nxt_cap;
    logic [IN_W-1:0] din_ff, nxt_din;
    logic [OUT_W-1:0] odata_ff, nxt_odata;
    logic [OUT_W-1:0] pout_ff, nxt_pout;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic [WD_W-1:0] mult_ff, nxt_mult;
    logic [WD_W-1:0] nwt_ff, nxt_nwt;
    logic [WD_W-1:0] lpt_ff, nxt_lpt;
    logic aw_got_ff, nxt_aw_got;
    logic w_got_ff, nxt_w_got;
    logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wd_tick, nw_exp, lp_exp, nw_armed, pd_ok, do_write;

    initial begin
        if (ADDR_W < 5 || OUT_W < 1 || OUT_W > 32 || IN_W < 1 || WD_W != 16) begin
            $error("swd_slave_ctrl: unsupported parameters");
        end
    end

    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(`SWD_OFS_CTRL) || a == ADDR_W'(`SWD_OFS_STATUS) || a == ADDR_W'(`SWD_OFS_MULT)
            || a == ADDR_W'(`SWD_OFS_NW_TIME) || a == ADDR_W'(`SWD_OFS_LP_TIME)
            || a == ADDR_W'(`SWD_OFS_OUT_DATA);
    endfunction

    // ***************************************************************
    // Watchdogs
    // ***************************************************************
    swd_tick_gen #(.MULT_W(WD_W)) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .mult(mult_ff),
        .tick(wd_tick)
    );

    // Exchange counts only while process data is allowed
    swd_wd_counter #(.CNT_W(WD_W)) u_nw_wd (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(ctrl_ff[`SWD_CTRL_NW_EN]),
        .timeout(nwt_ff),
        .restart(pd_xfer_ok && pd_ok),
        .tick(wd_tick),
        .expired(nw_exp)
    );

    swd_wd_counter #(.CNT_W(WD_W)) u_lp_wd (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(ctrl_ff[`SWD_CTRL_LP_EN]),
        .timeout(lpt_ff),
        .restart(lp_access),
        .tick(wd_tick),
        .expired(lp_exp)
    );

    assign nw_armed = ctrl_ff[`SWD_CTRL_NW_EN] && (nwt_ff != '0);

    // ***************************************************************
    // State controller
    // ***************************************************************
    assign pd_ok = (state_ff == swd_pkg::ST_SAFE_OPERATIONAL) || (state_ff == swd_pkg::ST_OPERATIONAL);

    always_comb begin
        nxt_state = state_ff;
        nxt_err = err_ff;
        nxt_cap = 1'b0;
        nxt_din = din_ff;
        nxt_odata = odata_ff;
        if (pd_ok && pd_xfer_ok) begin
            nxt_din = in_data;
            nxt_odata = pd_out_data;
        end
        if (req_valid && req_state != state_ff) begin
            nxt_err = 1'b1;
            unique case (req_state)
                swd_pkg::ST_INIT: nxt_err = 1'b0;
                swd_pkg::ST_PREOPERATIONAL: begin
                    // Mailbox setup checked on the way up
                    if (state_ff != swd_pkg::ST_INIT && state_ff != swd_pkg::ST_BOOT) begin
                        nxt_err = 1'b0;
                    end else if (state_ff == swd_pkg::ST_INIT && mbx_cfg_ok) begin
                        nxt_err = 1'b0;
                    end
                end
                swd_pkg::ST_SAFE_OPERATIONAL: begin
                    if (state_ff == swd_pkg::ST_OPERATIONAL) begin
                        nxt_err = 1'b0;
                    end else if (state_ff == swd_pkg::ST_PREOPERATIONAL && pd_cfg_ok && dc_cfg_ok) begin
                        nxt_err = 1'b0;
                        nxt_cap = 1'b1;
                        nxt_din = in_data;
                    end
                end
                swd_pkg::ST_OPERATIONAL: begin
                    if (state_ff == swd_pkg::ST_SAFE_OPERATIONAL) nxt_err = 1'b0;
                end
                swd_pkg::ST_BOOT: begin
                    if (state_ff == swd_pkg::ST_INIT) nxt_err = 1'b0;
                end
                default: nxt_err = 1'b1;
            endcase
            if (!nxt_err) nxt_state = req_state;
        end else if (req_valid) begin
            nxt_err = 1'b0;
        end
    end

    // Outputs: operational copies data, safe_operational_state holds safe unless unwatched
    always_comb begin
        nxt_pout = '0;
        if (state_ff == swd_pkg::ST_OPERATIONAL && !nw_exp) begin
            nxt_pout = odata_ff;
        end else if (state_ff == swd_pkg::ST_SAFE_OPERATIONAL && !nw_armed) begin
            nxt_pout = odata_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= swd_pkg::ST_INIT;
            err_ff <= 1'b0;
            cap_ff <= 1'b0;
            din_ff <= '0;
            odata_ff <= '0;
            pout_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            err_ff <= nxt_err;
            cap_ff <= nxt_cap;
            din_ff <= nxt_din;
            odata_ff <= nxt_odata;
            pout_ff <= nxt_pout;
        end
    end

    assign mbx_allowed = (state_ff != swd_pkg::ST_INIT);
    assign file_only = (state_ff == swd_pkg::ST_BOOT);
    assign pd_allowed = pd_ok;
    assign cur_state = state_ff;
    assign state_err = err_ff;
    assign capture_inputs = cap_ff;
    assign dpm_in_data = din_ff;
    assign phys_out = pout_ff;
    assign nw_wd_expired = nw_exp;
    assign lp_wd_expired = lp_exp;

    // ***************************************************************
    // AXI4-Lite slave
    // ***************************************************************
    assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mult = mult_ff;
        nxt_nwt = nwt_ff;
        nxt_lpt = lpt_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            unique case (awaddr_ff)
                ADDR_W'(`SWD_OFS_CTRL): nxt_ctrl = 2'(merge_strb({30'h0, ctrl_ff}, wdata_ff, wstrb_ff));
                ADDR_W'(`SWD_OFS_MULT): begin
                    // Zero multiplier is out of range and ignored
                    if (16'(merge_strb({16'h0, mult_ff}, wdata_ff, wstrb_ff)) != 16'h0) begin
                        nxt_mult = 16'(merge_strb({16'h0, mult_ff}, wdata_ff, wstrb_ff));
                    end
                end
                ADDR_W'(`SWD_OFS_NW_TIME): nxt_nwt = 16'(merge_strb({16'h0, nwt_ff}, wdata_ff, wstrb_ff));
                ADDR_W'(`SWD_OFS_LP_TIME): nxt_lpt = 16'(merge_strb({16'h0, lpt_ff}, wdata_ff, wstrb_ff));
                default: ;
            endcase
        end
        if (bvalid_ff && s_axi_bready) nxt_bvalid = 1'b0;
    end

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                ADDR_W'(`SWD_OFS_CTRL): nxt_rdata = {30'h0, ctrl_ff};
                ADDR_W'(`SWD_OFS_STATUS): nxt_rdata = {26'h0, lp_exp, nw_exp, err_ff, state_ff};
                ADDR_W'(`SWD_OFS_MULT): nxt_rdata = {16'h0, mult_ff};
                ADDR_W'(`SWD_OFS_NW_TIME): nxt_rdata = {16'h0, nwt_ff};
                ADDR_W'(`SWD_OFS_LP_TIME): nxt_rdata = {16'h0, lpt_ff};
                ADDR_W'(`SWD_OFS_OUT_DATA): nxt_rdata = 32'(odata_ff);
                default: nxt_rdata = 32'h0;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0;
            ctrl_ff <= `SWD_RST_CTRL;
            mult_ff <= `SWD_RST_MULT;
            nwt_ff <= `SWD_RST_NW_TIME;
            lpt_ff <= `SWD_RST_LP_TIME;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            mult_ff <= nxt_mult;
            nwt_ff <= nxt_nwt;
            lpt_ff <= nxt_lpt;
        end
    end

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // ***************************************************************
    // Checks
    // ***************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    expiry_forces_off_a: assert property (nw_exp |=> phys_out == '0) else $error("outputs live after expiry");
    expiry_keeps_state_a: assert property ($rose(nw_exp) && !$past(req_valid) |-> $stable(state_ff))
        else $error("expiry changed state");
    init_blocks_all_a: assert property (state_ff == swd_pkg::ST_INIT |-> !mbx_allowed && !pd_allowed)
        else $error("traffic in initial state");
    mbx_check_a: assert property (req_valid && req_state == swd_pkg::ST_PREOPERATIONAL
        && state_ff == swd_pkg::ST_INIT && !mbx_cfg_ok |=> state_ff == swd_pkg::ST_INIT && state_err)
        else $error("unchecked preop entry");
    safeop_capture_a: assert property ($changed(state_ff) && state_ff == swd_pkg::ST_SAFE_OPERATIONAL
        && $past(state_ff) == swd_pkg::ST_PREOPERATIONAL |-> capture_inputs)
        else $error("no input capture");
    safeop_safe_a: assert property (state_ff == swd_pkg::ST_SAFE_OPERATIONAL && nw_armed
        ##1 state_ff == swd_pkg::ST_SAFE_OPERATIONAL |-> phys_out == '0) else $error("safe_operational_state outputs live");
    boot_only_init_a: assert property (req_valid && req_state == swd_pkg::ST_BOOT
        && state_ff != swd_pkg::ST_INIT && state_ff != swd_pkg::ST_BOOT |=> state_err && $stable(state_ff))
        else $error("boot from wrong state");
    op_copies_a: assert property (state_ff == swd_pkg::ST_OPERATIONAL && !nw_exp
        ##1 state_ff == swd_pkg::ST_OPERATIONAL |-> phys_out == $past(odata_ff)) else $error("outputs not copied");
endmodule

//--- swd_consts.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * slave state controller and its network and local watchdogs.
 * Assumes inclusion by bare name from the controller, tick generator and bench.
 */
// Function
// - Two watchdogs, network and local, 100 ms
// - Only successful exchange restarts network watchdog
// - Network expiry clears outputs, state kept
// - Local watchdog fires without processor access
// - Shared multiplier, separate timeout per watchdog
// - Tick is multiplier plus two base periods
// - Default multiplier 2498 gives 100 us tick
// - Network default 1000 ticks, 100 ms
// - Counts 0..65535, multiplier 1..65535
// - Count zero disables network watchdog entirely
// - Five states, initial after reset
// - Initial state blocks mailbox and process data
// - Initial to preoperational checks mailbox setup
// - Preoperational allows mailbox, blocks process data
// - Safe_operational_state entry from preoperational checks setup, captures inputs
// - Safe_operational_state: traffic allowed, outputs held safe
// - Watchdog off lets safe_operational_state drive outputs
// - Operational copies master data to outputs
// - Boot only from initial, file transfer only
`ifndef SWD_CONSTS_SVH
`define SWD_CONSTS_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define SWD_OFS_CTRL 8'h00
`define SWD_OFS_STATUS 8'h04
`define SWD_OFS_MULT 8'h08
`define SWD_OFS_NW_TIME 8'h0C
`define SWD_OFS_LP_TIME 8'h10
`define SWD_OFS_OUT_DATA 8'h14

// ***************************************************************
// Field positions
// ***************************************************************
`define SWD_CTRL_NW_EN 0
`define SWD_CTRL_LP_EN 1
`define SWD_STAT_ERR 3
`define SWD_STAT_NW_EXP 4
`define SWD_STAT_LP_EXP 5

// ***************************************************************
// Reset values and timing
// ***************************************************************
`define SWD_RST_CTRL 2'h3
`define SWD_RST_MULT 16'd2498
`define SWD_RST_NW_TIME 16'd1000
`define SWD_RST_LP_TIME 16'd1000
`define SWD_CLK_PERIOD_NS 20
`define SWD_BASE_PERIOD_NS 40
`define SWD_CLKS_PER_BASE (`SWD_BASE_PERIOD_NS / `SWD_CLK_PERIOD_NS)
`define SWD_MULT_EXTRA 16'd2

`endif

//--- swd_pkg.sv
/*
 * Types shared by the slave state controller, master model and bench.
 * Assumes nothing of its surroundings.
 */
package swd_pkg;
    typedef enum logic [2:0] {
        ST_INIT,
        ST_PREOPERATIONAL,
        ST_SAFE_OPERATIONAL,
        ST_OPERATIONAL,
        ST_BOOT
    } swd_state_t;
endpackage

//--- swd_tick_gen.sv
/*
 * Shared watchdog tick prescaler: one tick every multiplier plus two
 * base periods of the 25 MHz base clock.
 * Assumes aclk at 50 MHz and a multiplier of at least one.
 */
`timescale 1ns/1ns
`include "swd_consts.svh"

module swd_tick_gen #(
    parameter int MULT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [MULT_W-1:0] mult,
    output logic tick
);
    logic [1:0] base_cnt_ff, nxt_base_cnt;
    logic [MULT_W:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick_ff, nxt_tick;
    logic base_end;

    initial begin
        if (MULT_W < 2 || `SWD_CLKS_PER_BASE > 4) $error("swd_tick_gen: unsupported width");
    end

    assign base_end = (base_cnt_ff == 2'(`SWD_CLKS_PER_BASE - 1));

    always_comb begin
        nxt_base_cnt = base_end ? 2'h0 : base_cnt_ff + 2'h1;
        nxt_tick_cnt = tick_cnt_ff;
        nxt_tick = 1'b0;
        if (base_end) begin
            // Count multiplier + 2 base periods per tick
            if (tick_cnt_ff >= {1'b0, mult} + (MULT_W+1)'(`SWD_MULT_EXTRA - 16'd1)) begin
                nxt_tick_cnt = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_tick_cnt = tick_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_cnt_ff <= 2'h0;
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            base_cnt_ff <= nxt_base_cnt;
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tick_single_a: assert property (tick |=> !tick [*3]) else $error("tick too close");
    tick_base_a: assert property (tick |-> $past(base_end)) else $error("tick off base edge");
endmodule

//--- swd_wd_counter.sv
/*
 * One watchdog: counts shared ticks since its last restart and flags
 * expiry when its own timeout count is reached.
 * Assumes tick is a one-cycle pulse; a timeout of zero disables it.
 */
`timescale 1ns/1ns

module swd_wd_counter #(
    parameter int CNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic [CNT_W-1:0] timeout,
    input wire logic restart,
    input wire logic tick,
    output logic expired
);
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic exp_ff, nxt_exp;
    logic armed;

    initial begin
        if (CNT_W < 1) $error("swd_wd_counter: bad width");
    end

    assign armed = enable && (timeout != '0);

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_exp = exp_ff;
        if (!armed || restart) begin
            // Cleared while disarmed and on the caller's qualified restart event
            nxt_cnt = '0;
            nxt_exp = 1'b0;
        end else if (tick && !exp_ff) begin
            nxt_cnt = cnt_ff + 1'b1;
            // Period is timeout times tick; a lowered timeout still fires
            if (nxt_cnt >= timeout) begin
                nxt_exp = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            exp_ff <= nxt_exp;
        end
    end

    assign expired = exp_ff;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    restart_clears_a: assert property (restart |=> !expired) else $error("restart left expiry");
    zero_disables_a: assert property (timeout == '0 |=> !expired) else $error("zero timeout expired");
    expiry_cause_a: assert property ($rose(expired) |-> $past(tick) && $past(cnt_ff) >= $past(timeout) - 1'b1)
        else $error("expiry without full count");
endmodule

//--- swd_master_model.sv
/* Fieldbus master model: state requests and process-data exchanges.
   Assumes aclk; tasks are entered off the clock edge. */
`timescale 1ns/1ns
module swd_master_model (
    input wire logic aclk,
    output logic req_valid,
    output swd_pkg::swd_state_t req_state,
    output logic cfg_ok,
    output logic pd_xfer_ok,
    output logic [31:0] pd_out_data
);
    initial begin
        req_valid = 1'h0;
        req_state = swd_pkg::ST_INIT;
        cfg_ok = 1'h0;
        pd_xfer_ok = 1'h0;
        pd_out_data = 32'h0;
    end
    // Watchdog settings never written from here
    task automatic request(input swd_pkg::swd_state_t s, input logic ok);
        req_valid <= 1'h1;
        req_state <= s;
        cfg_ok <= ok;
        @(posedge aclk);
        req_valid <= 1'h0;
        cfg_ok <= ~ok;
        #1;
    endtask
    // Drives output data with pd_xfer_ok for one cycle, then inverted data
    task automatic exchange(input logic [31:0] d);
        pd_xfer_ok <= 1'h1;
        pd_out_data <= d;
        @(posedge aclk);
        pd_xfer_ok <= 1'h0;
        pd_out_data <= ~d;
        #1;
    endtask
endmodule

//--- swd_slave_ctrl_bench.sv
/* Self-checking bench for swd_slave_ctrl with an AXI4-Lite master.
   Assumes swd_master_model drives the state link and exchanges. */
`timescale 1ns/1ns
`include "swd_consts.svh"
module swd_slave_ctrl_bench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, lp_access;
    logic cfg_ok, req_valid, pd_xfer_ok, mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, state_err;
    logic mbx_allowed, file_only, pd_allowed, capture_inputs, nw_wd_expired, lp_wd_expired;
    logic [31:0] s_axi_wdata, s_axi_rdata, pd_out_data, in_data, dpm_in_data, phys_out, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    swd_pkg::swd_state_t req_state, cur_state;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    assign {mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok} = {3{cfg_ok}};
    swd_slave_ctrl uut (.*);
    swd_master_model m (.*);
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ****
    // Helpers
    // ****
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cs(input swd_pkg::swd_state_t e);
        chk(32'(cur_state), 32'(e));
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic da, dw, db;
        {da, dw, db} = 3'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!db) begin
            @(negedge aclk);
            {da, dw, db} = {da | s_axi_awready, dw | s_axi_wready, s_axi_bvalid};
            r = s_axi_bresp;
            @(posedge aclk);
            if (da) s_axi_awvalid <= 1'h0;
            if (dw) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        #1;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic da, dr;
        {da, dr} = 2'h0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!dr) begin
            @(negedge aclk);
            {da, dr} = {da | s_axi_arready, s_axi_rvalid};
            {d, r} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (da) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        #1;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        axr(`SWD_OFS_CTRL, rd, rs); chk(rd, 32'h3);
        axr(`SWD_OFS_LP_TIME, rd, rs); chk(rd, 32'h3E8);
        axr(`SWD_OFS_NW_TIME, rd, rs); chk(rd, 32'h3E8);
        axr(`SWD_OFS_STATUS, rd, rs); chk(rd, 32'h0);
        axw(`SWD_OFS_MULT, 32'h0, rs);
        axr(`SWD_OFS_MULT, rd, rs); chk(rd, 32'h9C2);
        axr(8'h40, rd, rs); chk(32'(rs), 32'h2);
        axw(8'h40, 32'h1, rs); chk(32'(rs), 32'h2);
        $display("regs done");
    endtask
    task automatic t_states();
        m.request(swd_pkg::ST_SAFE_OPERATIONAL, 1'h1); cs(swd_pkg::ST_INIT); chk(32'(state_err), 32'h1);
        m.request(swd_pkg::ST_PREOPERATIONAL, 1'h0); cs(swd_pkg::ST_INIT);
        m.request(swd_pkg::ST_PREOPERATIONAL, 1'h1); cs(swd_pkg::ST_PREOPERATIONAL);
        chk(32'({mbx_allowed, pd_allowed, state_err}), 32'h4);
        in_data <= 32'hC0DE_0001;
        m.request(swd_pkg::ST_SAFE_OPERATIONAL, 1'h1); chk(32'({capture_inputs, pd_allowed}), 32'h3);
        chk(dpm_in_data, 32'hC0DE_0001);
        m.exchange(32'hA5A5_0001); wt(1); chk(phys_out, 32'h0);
        m.request(swd_pkg::ST_OPERATIONAL, 1'h1); m.exchange(32'hA5A5_0002); wt(1);
        chk(phys_out, 32'hA5A5_0002);
        m.request(swd_pkg::ST_INIT, 1'h1); chk(32'({mbx_allowed, pd_allowed}), 32'h0);
        m.request(swd_pkg::ST_BOOT, 1'h1); chk(32'({file_only, pd_allowed}), 32'h2);
        m.request(swd_pkg::ST_PREOPERATIONAL, 1'h1); cs(swd_pkg::ST_BOOT);
        m.request(swd_pkg::ST_INIT, 1'h1);
        $display("states done");
    endtask
    task automatic t_wd();
        axw(`SWD_OFS_MULT, 32'h1, rs);
        axw(`SWD_OFS_NW_TIME, 32'h3, rs);
        m.request(swd_pkg::ST_PREOPERATIONAL, 1'h1);
        m.request(swd_pkg::ST_SAFE_OPERATIONAL, 1'h1);
        m.request(swd_pkg::ST_OPERATIONAL, 1'h1);
        m.exchange(32'h5A5A_0003); wt(7); chk(phys_out, 32'h5A5A_0003);
        wt(20); chk(phys_out, 32'h0);
        chk(32'(nw_wd_expired), 32'h1);
        cs(swd_pkg::ST_OPERATIONAL);
        axw(`SWD_OFS_NW_TIME, 32'h0, rs);
        m.exchange(32'h5A5A_0004); wt(30); chk(phys_out, 32'h5A5A_0004);
        axw(`SWD_OFS_NW_TIME, 32'h3, rs);
        axw(`SWD_OFS_CTRL, 32'h2, rs);
        m.request(swd_pkg::ST_SAFE_OPERATIONAL, 1'h1);
        m.exchange(32'h5A5A_0005); wt(1); chk(phys_out, 32'h5A5A_0005);
        $display("network watchdog done");
    endtask
    task automatic t_lp();
        axw(`SWD_OFS_LP_TIME, 32'h3, rs);
        wt(30); chk(32'(lp_wd_expired), 32'h1);
        lp_access <= 1'h1;
        wt(1);
        lp_access <= 1'h0;
        wt(2); chk(32'(lp_wd_expired), 32'h0);
        $display("local watchdog done");
    endtask
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, in_data} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, lp_access} = '0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        #1;
        t_regs();
        t_states();
        t_wd();
        t_lp();
        wrap_up();
    end
endmodule
